/* File: include/rbx_pkg.sv */
package rbx_pkg;
    // program counter and word widths
    localparam int PC_W          = 21;
    localparam int WORD_W        = 16;
    // opcode fields
    localparam int OP_HI_POS     = 8;
    localparam int OP_BRA_POS    = 11;
    localparam logic [7:0] OP_CARRY_SET   = 8'hE2;
    localparam logic [7:0] OP_CARRY_CLEAR = 8'hE3;
    localparam logic [7:0] OP_NEGATIVE    = 8'hE6;
    localparam logic [7:0] OP_NONZERO     = 8'hE1;
    localparam logic [4:0] OP_JUMP        = 5'h1A;
    localparam int SHORT_OFF_W   = 8;
    localparam int LONG_OFF_W    = 11;
    // quarter cycles per instruction cycle, pc write in the last
    localparam logic [1:0] Q_LAST = 2'h3;
    localparam logic [1:0] Q_FIRST = 2'h0;
    // reset values
    localparam logic [PC_W-1:0] PC_RESET = 21'h00_0000;

    typedef enum logic [1:0] {
        RBX_KIND_NONE,
        RBX_KIND_COND,
        RBX_KIND_JUMP
    } rbx_kind_e;

    typedef enum logic {
        RBX_ST_EXEC,
        RBX_ST_FLUSH
    } rbx_state_e;
endpackage

/* File: verilog/rbx_decode.sv */
`timescale 1ns/1ps
module rbx_decode
    import rbx_pkg::*;
(
    input  wire logic [WORD_W-1:0] word_in,
    input  wire logic              carry_in,
    input  wire logic              negative_in,
    input  wire logic              zero_in,
    output rbx_kind_e              kind_out,
    output logic                   taken_out,
    output logic [PC_W-1:0]        disp_out
);
    logic [7:0] hi;

    // opcode recognition, condition test and doubled sign-extended offset
    always_comb
    begin
        hi        = word_in[WORD_W-1:OP_HI_POS];
        kind_out  = RBX_KIND_NONE;
        taken_out = 1'b0;
        disp_out  = '0;
        if (word_in[WORD_W-1:OP_BRA_POS] == OP_JUMP)
        begin
            kind_out  = RBX_KIND_JUMP;
            taken_out = 1'b1;
            disp_out  = {{(PC_W-LONG_OFF_W-1){word_in[LONG_OFF_W-1]}},
                         word_in[LONG_OFF_W-1:0], 1'b0};
        end
        else if (hi == OP_CARRY_SET || hi == OP_CARRY_CLEAR ||
                 hi == OP_NEGATIVE || hi == OP_NONZERO)
        begin
            kind_out = RBX_KIND_COND;
            disp_out = {{(PC_W-SHORT_OFF_W-1){word_in[SHORT_OFF_W-1]}},
                        word_in[SHORT_OFF_W-1:0], 1'b0};
            if (hi == OP_CARRY_SET)
                taken_out = carry_in;
            else if (hi == OP_CARRY_CLEAR)
                taken_out = !carry_in;
            else if (hi == OP_NEGATIVE)
                taken_out = negative_in;
            else
                taken_out = !zero_in;
        end
    end
endmodule

/* File: verilog/rbx_exec.sv */
`timescale 1ns/1ps
module rbx_exec
    import rbx_pkg::*;
(
    input  wire logic            core_clk_in,
    input  wire logic            reset_n_in,
    input  wire logic            word_valid_in,
    input  wire logic [WORD_W-1:0] word_in,
    input  wire logic [PC_W-1:0] pc_inc_in,
    input  wire logic            carry_in,
    input  wire logic            negative_in,
    input  wire logic            zero_in,
    output logic                 pc_load_out,
    output logic [PC_W-1:0]      pc_target_out,
    output logic                 flush_out,
    output logic                 busy_out,
    output logic                 flags_we_out
);
    typedef struct packed {
        rbx_state_e      st;
        logic [1:0]      q;
        logic            load;
        logic [PC_W-1:0] target;
    } rbx_state_s;

    rbx_state_s cur;
    rbx_state_s next_cur;
    rbx_kind_e  kind;
    logic       taken;
    logic [PC_W-1:0] disp;

    rbx_decode u_dec (
        .word_in     (word_in),
        .carry_in    (carry_in),
        .negative_in (negative_in),
        .zero_in     (zero_in),
        .kind_out    (kind),
        .taken_out   (taken),
        .disp_out    (disp)
    );

    // quarter counter, branch decision and flush sequencing
    always_comb
    begin
        next_cur      = cur;
        next_cur.q    = cur.q + 2'h1;
        next_cur.load = 1'b0;
        case (cur.st)
            RBX_ST_EXEC:
            begin
                if (cur.q == Q_LAST - 2'h1 && word_valid_in && taken
                    && kind != RBX_KIND_NONE)
                begin
                    next_cur.load   = 1'b1;
                    next_cur.target = pc_inc_in + disp;
                end
                if (cur.q == Q_LAST && cur.load)
                    next_cur.st = RBX_ST_FLUSH;
            end
            RBX_ST_FLUSH:
            begin
                if (cur.q == Q_LAST)
                    next_cur.st = RBX_ST_EXEC;
            end
            default:
                next_cur.st = RBX_ST_EXEC;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            cur.st     <= RBX_ST_EXEC;
            cur.q      <= Q_FIRST;
            cur.load   <= 1'b0;
            cur.target <= PC_RESET;
        end
        else
            cur <= next_cur;
    end

    // outputs
    assign pc_load_out   = cur.load;
    assign pc_target_out = cur.target;
    assign flush_out     = (cur.st == RBX_ST_FLUSH);
    assign busy_out      = (cur.st == RBX_ST_FLUSH) || cur.load;
    assign flags_we_out  = 1'b0;

    property p_load_late;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        cur.load |-> cur.q == Q_LAST;
    endproperty
    a_load_late: assert property (p_load_late) else $error("pc load not in last quarter");

    sequence s_load;
        cur.load;
    endsequence
    sequence s_flush4;
        flush_out [*4];
    endsequence
    property p_flush;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        s_load |=> s_flush4 ##1 !flush_out;
    endproperty
    a_flush: assert property (p_flush) else $error("taken branch lacks one flush cycle");

    property p_jump;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (cur.st == RBX_ST_EXEC && cur.q == 2'h2 && word_valid_in
         && word_in[WORD_W-1:OP_BRA_POS] == OP_JUMP) |=> cur.load;
    endproperty
    a_jump: assert property (p_jump) else $error("jump not taken");

    property p_nojump;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (cur.st == RBX_ST_EXEC && cur.q == 2'h2 && !taken) |=> !cur.load;
    endproperty
    a_nojump: assert property (p_nojump) else $error("failed condition loaded pc");

    property p_target;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (cur.st == RBX_ST_EXEC && cur.q == 2'h2 && word_valid_in && taken
         && kind != RBX_KIND_NONE) |=> pc_target_out == $past(pc_inc_in) + $past(disp);
    endproperty
    a_target: assert property (p_target) else $error("wrong branch target");

    property p_carry;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (word_in[15:8] == OP_CARRY_SET) |-> taken == carry_in;
    endproperty
    a_carry: assert property (p_carry) else $error("carry set test wrong");

    property p_nocarry;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (word_in[15:8] == OP_CARRY_CLEAR) |-> taken == !carry_in;
    endproperty
    a_nocarry: assert property (p_nocarry) else $error("carry clear test wrong");

    property p_neg;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (word_in[15:8] == OP_NEGATIVE) |-> taken == negative_in;
    endproperty
    a_neg: assert property (p_neg) else $error("negative test wrong");

    property p_nz;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (word_in[15:8] == OP_NONZERO) |-> taken == !zero_in;
    endproperty
    a_nz: assert property (p_nz) else $error("nonzero test wrong");

    property p_flags;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        flush_out |-> !flags_we_out && !pc_load_out;
    endproperty
    a_flags: assert property (p_flags) else $error("flush cycle not idle");

    // the quarter counter steps by one on every clock once out of reset
    property p_quarter;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        $past(reset_n_in) |-> cur.q == $past(cur.q) + 2'h1;
    endproperty
    a_quarter: assert property (p_quarter) else $error("quarter counter skipped");

    // the branch target holds until the next pc load
    property p_target_hold;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        ($past(reset_n_in) && !pc_load_out) |-> $stable(pc_target_out);
    endproperty
    a_target_hold: assert property (p_target_hold) else $error("branch target drifted");

    // flush only ever follows a pc load
    property p_flush_cause;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        $rose(flush_out) |-> $past(pc_load_out);
    endproperty
    a_flush_cause: assert property (p_flush_cause) else $error("flush without pc load");

    // a word offered during the flush cycle is discarded
    property p_flush_refuses;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (flush_out && cur.q == 2'h2 && word_valid_in) |=> !pc_load_out;
    endproperty
    a_flush_refuses: assert property (p_flush_refuses) else $error("flushed word ran");

    // no valid recognised word, no pc load
    property p_idle;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (cur.st == RBX_ST_EXEC && cur.q == 2'h2 && (!word_valid_in || kind == RBX_KIND_NONE))
        |=> !pc_load_out;
    endproperty
    a_idle: assert property (p_idle) else $error("pc loaded without a branch");

    // failed condition: a single cycle, no load and no flush
    sequence s_cond_fails;
        cur.st == RBX_ST_EXEC && cur.q == 2'h2 && word_valid_in
            && kind == RBX_KIND_COND && !taken;
    endsequence
    property p_cond_fails;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        s_cond_fails |=> !pc_load_out ##1 !flush_out;
    endproperty
    a_cond_fails: assert property (p_cond_fails) else $error("failed condition stalled");

    // jump: pc load, four flush clocks, then back to execution
    sequence s_jump_seen;
        cur.st == RBX_ST_EXEC && cur.q == 2'h2 && word_valid_in
            && word_in[WORD_W-1:OP_BRA_POS] == OP_JUMP;
    endsequence
    property p_jump_two;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        s_jump_seen |=> pc_load_out ##1 s_flush4 ##1 !flush_out;
    endproperty
    a_jump_two: assert property (p_jump_two) else $error("jump not two cycles");
endmodule

/* File: bench/rbx_exec_tb.sv */
`timescale 1ns/1ps
module rbx_exec_tb
    import rbx_pkg::*;
;
    logic              core_clk_in;
    logic              reset_n_in;
    logic              word_valid_in;
    logic [WORD_W-1:0] word_in;
    logic [PC_W-1:0]   pc_inc_in;
    logic              carry_in;
    logic              negative_in;
    logic              zero_in;
    logic              pc_load_out;
    logic [PC_W-1:0]   pc_target_out;
    logic              flush_out;
    logic              busy_out;
    logic              flags_we_out;
    logic [PC_W-1:0]   last_tgt;
    int                bad_count;
    int                num_checks;

    rbx_exec rbx_exec_i (
        .core_clk_in   (core_clk_in),
        .reset_n_in    (reset_n_in),
        .word_valid_in (word_valid_in),
        .word_in       (word_in),
        .pc_inc_in     (pc_inc_in),
        .carry_in      (carry_in),
        .negative_in   (negative_in),
        .zero_in       (zero_in),
        .pc_load_out   (pc_load_out),
        .pc_target_out (pc_target_out),
        .flush_out     (flush_out),
        .busy_out      (busy_out),
        .flags_we_out  (flags_we_out)
    );

    // 4 ns core clock
    initial
    begin
        core_clk_in = 1'b0;
        forever #2 core_clk_in = ~core_clk_in;
    end

    // compare one value and count it
    task automatic chk(input logic [PC_W-1:0] seen, input logic [PC_W-1:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic print_verdict();
        if (bad_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // one instruction cycle; a taken one also spans the flush cycle,
    // during which a jump word is offered and must be ignored
    task automatic run_instr(input logic [WORD_W-1:0] w, input logic [PC_W-1:0] pc,
                             input logic [2:0] flg, input logic vld, input logic tk,
                             input logic [PC_W-1:0] tgt);
        logic ld;
        logic fl;
        word_valid_in = vld;
        word_in = w;
        pc_inc_in = pc;
        {carry_in, negative_in, zero_in} = flg;
        for (int i = 1; i <= (tk ? 8 : 4); i++)
        begin
            @(negedge core_clk_in);
            ld = tk && (i == 3);
            fl = tk && (i >= 4) && (i <= 7);
            if (ld)
                last_tgt = tgt;
            if (tk && i == 4)
                word_in = {OP_JUMP, 11'h007};
            chk(21'({pc_load_out, flush_out, busy_out, flags_we_out}),
                21'({ld, fl, ld | fl, 1'b0}));
            chk(pc_target_out, last_tgt);
        end
    endtask

    // each conditional opcode with its condition true then all flags inverted, offsets at both ends
    task automatic t_cond();
        logic [7:0] ops [4];
        logic [2:0] hit [4];
        logic [7:0] n;
        ops = '{OP_CARRY_SET, OP_CARRY_CLEAR, OP_NEGATIVE, OP_NONZERO};
        hit = '{3'b101, 3'b010, 3'b011, 3'b110};
        for (int i = 0; i < 8; i++)
        begin
            n = i[2] ? 8'h80 : 8'h7F;
            run_instr({ops[i[1:0]], n}, 21'h00_0040, hit[i[1:0]], 1'b1, 1'b1,
                      21'h00_0040 + {{12{n[7]}}, n, 1'b0});
            run_instr({ops[i[1:0]], n}, 21'h00_0040, ~hit[i[1:0]], 1'b1, 1'b0, '0);
        end
    endtask

    // unconditional jump at both offset limits, any flags
    task automatic t_jump();
        logic [10:0] n;
        for (int i = 0; i < 2; i++)
        begin
            n = i[0] ? 11'h400 : 11'h3FF;
            run_instr({OP_JUMP, n}, 21'h10_0000, {3{i[0]}}, 1'b1, 1'b1,
                      21'h10_0000 + {{9{n[10]}}, n, 1'b0});
        end
    endtask

    // foreign opcodes and an invalid word do nothing
    task automatic t_refused();
        logic [15:0] ws [4];
        ws = '{16'hE07F, 16'hD87F, 16'hE47F, 16'hD001};
        for (int i = 0; i < 4; i++)
            run_instr(ws[i], 21'h00_0100, 3'b111, i < 3, 1'b0, '0);
    endtask

    // reset in mid flush clears every output and realigns the quarters
    task automatic t_reset();
        word_valid_in = 1'b1;
        word_in = {OP_JUMP, 11'h001};
        pc_inc_in = 21'h00_0200;
        repeat (5) @(negedge core_clk_in);
        reset_n_in = 1'b0;
        @(negedge core_clk_in);
        chk(21'({pc_load_out, flush_out, busy_out, flags_we_out}), 21'h00_0000);
        chk(pc_target_out, PC_RESET);
        reset_n_in = 1'b1;
        last_tgt = PC_RESET;
        run_instr({OP_CARRY_SET, 8'h01}, 21'h00_0010, 3'b100, 1'b1, 1'b1, 21'h00_0012);
    endtask

    // reset, then the scenarios
    initial
    begin
        bad_count = 0;
        num_checks = 0;
        last_tgt = '0;
        reset_n_in = 1'b0;
        word_valid_in = 1'b0;
        word_in = '0;
        pc_inc_in = '0;
        {carry_in, negative_in, zero_in} = 3'b000;
        repeat (10) @(posedge core_clk_in);
        @(negedge core_clk_in);
        reset_n_in = 1'b1;
        t_cond();
        t_jump();
        t_refused();
        t_reset();
        print_verdict();
    end

    // watchdog, well beyond the expected run
    initial
    begin
        #(4 * 5000);
        bad_count++;
        print_verdict();
    end
endmodule
